// ==== design/ble_core.sv ====
// decode and execute core for add, and, bit and skip instructions
`timescale 1ns/1ps
module ble_core
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // instruction stream from fetch
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    output logic instr_ready,
    output logic instr_discard,
    output logic skip_taken,
    // io port pins
    input wire logic [7:0] port_pins,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    output logic prescale_clear,
    // classic wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ble_pkg::ble_state_t state;
    ble_pkg::ble_state_t next_state;
    logic [11:0] ir;
    logic [11:0] next_ir;
    logic skip_pend;
    logic next_skip_pend;
    logic discarded;
    logic next_discarded;
    logic [7:0] acc;
    logic [7:0] next_acc;
    ble_pkg::ble_flags_t flags;
    ble_pkg::ble_flags_t next_flags;
    logic [7:0] latch;
    logic [7:0] next_latch;
    logic [7:0] dir;
    logic [7:0] next_dir;
    logic [7:0] presc;
    logic [7:0] next_presc;
    logic ctl_run;
    logic next_ctl_run;
    logic ctl_pre_tmr;
    logic next_ctl_pre_tmr;
    logic unsup;
    logic next_unsup;
    logic next_discard;
    logic next_skip_taken;
    logic next_presc_clear;
    logic next_ack;
    logic [31:0] next_dat_r;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [4:0] fa;
    logic dbit;
    logic [2:0] bsel;
    logic [7:0] lit;
    logic [7:0] mask;
    logic [7:0] opnd;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] mem_rd;
    logic is_add;
    logic is_andf;
    logic is_move_file_value;
    logic is_andl;
    logic is_bclr;
    logic is_bset;
    logic is_skc;
    logic is_sks;
    logic is_dir;
    logic is_nop;
    logic exec;
    logic accept;

    // instruction fields
    assign fa = ir[4:0];
    assign dbit = ir[5];
    assign bsel = ir[7:5];
    assign lit = ir[7:0];
    assign mask = 8'h01 << bsel;
    assign is_add = ir[11:6] == ble_pkg::BLE_OP_ADD;
    assign is_andf = ir[11:6] == ble_pkg::BLE_OP_ANDF;
    assign is_move_file_value = ir[11:6] == ble_pkg::BLE_OP_MOVE_FILE_VALUE;
    assign is_andl = ir[11:8] == ble_pkg::BLE_OP_ANDL;
    assign is_bclr = ir[11:8] == ble_pkg::BLE_OP_BCLR;
    assign is_bset = ir[11:8] == ble_pkg::BLE_OP_BSET;
    assign is_skc = ir[11:8] == ble_pkg::BLE_OP_SKC;
    assign is_sks = ir[11:8] == ble_pkg::BLE_OP_SKS;
    assign is_dir = ir == ble_pkg::BLE_OP_DIR;
    assign is_nop = ir == ble_pkg::BLE_OP_NOP;
    assign exec = state == ble_pkg::BLE_S_EXEC;
    assign accept = instr_valid && instr_ready;

    // port operand comes from the pins, not the output latch
    assign opnd = (fa == ble_pkg::BLE_FILE_PORT) ? port_pins : mem_rd;
    assign sum9 = {1'b0, acc} + {1'b0, opnd};
    assign nib5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};

    // handshake: one instruction taken per two cycles while running
    assign instr_ready = ctl_run && (state == ble_pkg::BLE_S_IDLE);
    assign port_out = latch;
    assign port_oe = ~dir;

    // ----------------------------------------------------------------
    // execute datapath
    // ----------------------------------------------------------------
    logic [7:0] res;
    logic to_acc;
    logic to_file;
    logic upd_z;
    logic upd_cdc;
    logic do_skip;
    logic mem_we;

    // result, destination and flag selection of the current instruction
    always_comb
    begin
        res = 8'h00;
        to_acc = 1'b0;
        to_file = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        do_skip = 1'b0;
        if (is_add)
        begin
            res = sum9[7:0];
            upd_z = 1'b1;
            upd_cdc = 1'b1;
            to_acc = !dbit;
            to_file = dbit;
        end
        else if (is_andf)
        begin
            res = acc & opnd;
            upd_z = 1'b1;
            to_acc = !dbit;
            to_file = dbit;
        end
        else if (is_move_file_value)
        begin
            res = opnd;
            upd_z = 1'b1;
            to_acc = !dbit;
            to_file = dbit;
        end
        else if (is_andl)
        begin
            res = acc & lit;
            upd_z = 1'b1;
            to_acc = 1'b1;
        end
        else if (is_bclr)
        begin
            res = opnd & ~mask;
            to_file = 1'b1;
        end
        else if (is_bset)
        begin
            res = opnd | mask;
            to_file = 1'b1;
        end
        else if (is_skc)
        begin
            do_skip = !opnd[bsel];
        end
        else if (is_sks)
        begin
            do_skip = opnd[bsel];
        end
    end

    assign mem_we = exec && to_file && (fa != ble_pkg::BLE_FILE_PORT);

    // file register storage
    ble_regfile u_regfile
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rd_addr(instr_word[4:0]),
        .rd_data(mem_rd),
        .wr_en(mem_we),
        .wr_addr(fa),
        .wr_data(res)
    );

    // ----------------------------------------------------------------
    // sequencer and core state
    // ----------------------------------------------------------------
    logic bus_hit;
    logic bus_wr;

    assign bus_hit = wb_cyc && wb_stb && !wb_ack;
    assign bus_wr = bus_hit && wb_we && wb_sel[0];

    // next values of sequencer, accumulator, flags, port and prescaler
    always_comb
    begin
        next_state = state;
        next_ir = ir;
        next_skip_pend = skip_pend;
        next_discarded = discarded;
        next_acc = acc;
        next_flags = flags;
        next_latch = latch;
        next_dir = dir;
        next_presc = ctl_run ? presc + 8'h01 : presc;
        next_unsup = unsup;
        next_discard = 1'b0;
        next_skip_taken = 1'b0;
        next_presc_clear = 1'b0;
        case (state)
            ble_pkg::BLE_S_IDLE:
            begin
                if (accept)
                begin
                    // a word fetched behind a taken skip runs as no_operation
                    next_ir = skip_pend ? ble_pkg::BLE_OP_NOP : instr_word;
                    next_discarded = skip_pend;
                    next_skip_pend = 1'b0;
                    next_state = ble_pkg::BLE_S_EXEC;
                end
            end
            ble_pkg::BLE_S_EXEC:
            begin
                next_state = ble_pkg::BLE_S_IDLE;
                next_discard = discarded;
                if (to_acc)
                begin
                    next_acc = res;
                end
                if (upd_z)
                begin
                    next_flags.zero = res == 8'h00;
                end
                if (upd_cdc)
                begin
                    next_flags.carry = sum9[8];
                    next_flags.nibble_carry_flag = nib5[4];
                end
                if (to_file && (fa == ble_pkg::BLE_FILE_PORT))
                begin
                    next_latch = res;
                end
                if (to_file && (fa == ble_pkg::BLE_FILE_TIMER) && ctl_pre_tmr)
                begin
                    next_presc = ble_pkg::BLE_PRESC_RST;
                    next_presc_clear = 1'b1;
                end
                if (is_dir)
                begin
                    next_dir = acc;
                end
                if (do_skip)
                begin
                    next_skip_pend = 1'b1;
                    next_skip_taken = 1'b1;
                end
                if (!(is_add || is_andf || is_move_file_value || is_andl || is_bclr || is_bset
                      || is_skc || is_sks || is_dir || is_nop))
                begin
                    next_unsup = 1'b1;
                end
            end
            default:
            begin
                next_state = ble_pkg::BLE_S_IDLE;
            end
        endcase
        // bus writes to acc and flags only land outside execute cycles
        if (bus_wr && !exec && (wb_adr == ble_pkg::BLE_REG_ACC))
        begin
            next_acc = wb_dat_w[7:0];
        end
        if (bus_wr && !exec && (wb_adr == ble_pkg::BLE_REG_FLAGS))
        begin
            next_flags = wb_dat_w[2:0];
        end
        // sticky unsupported bit: write one clears, a new event wins only while the bit is clear
        if (bus_wr && (wb_adr == ble_pkg::BLE_REG_STAT) && wb_dat_w[ble_pkg::BLE_STAT_UNSUP]
            && !(exec && next_unsup && !unsup))
        begin
            next_unsup = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ble_pkg::BLE_S_IDLE;
            ir <= ble_pkg::BLE_OP_NOP;
            skip_pend <= 1'b0;
            discarded <= 1'b0;
            acc <= ble_pkg::BLE_ACC_RST;
            flags <= ble_pkg::BLE_FLAGS_RST;
            latch <= ble_pkg::BLE_LATCH_RST;
            dir <= ble_pkg::BLE_DIR_RST;
            presc <= ble_pkg::BLE_PRESC_RST;
            unsup <= 1'b0;
            instr_discard <= 1'b0;
            skip_taken <= 1'b0;
            prescale_clear <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ir <= next_ir;
            skip_pend <= next_skip_pend;
            discarded <= next_discarded;
            acc <= next_acc;
            flags <= next_flags;
            latch <= next_latch;
            dir <= next_dir;
            presc <= next_presc;
            unsup <= next_unsup;
            instr_discard <= next_discard;
            skip_taken <= next_skip_taken;
            prescale_clear <= next_presc_clear;
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------

    // control bits, read mux and single-cycle acknowledge
    always_comb
    begin
        next_ctl_run = ctl_run;
        next_ctl_pre_tmr = ctl_pre_tmr;
        next_ack = bus_hit;
        next_dat_r = 32'h0000_0000;
        if (bus_wr && (wb_adr == ble_pkg::BLE_REG_CTRL))
        begin
            next_ctl_run = wb_dat_w[ble_pkg::BLE_CTRL_RUN];
            next_ctl_pre_tmr = wb_dat_w[ble_pkg::BLE_CTRL_PRE_TMR];
        end
        if (bus_hit && !wb_we)
        begin
            if (wb_adr == ble_pkg::BLE_REG_CTRL)
            begin
                next_dat_r = {30'h0000_0000, ctl_pre_tmr, ctl_run};
            end
            else if (wb_adr == ble_pkg::BLE_REG_ACC)
            begin
                next_dat_r = {24'h00_0000, acc};
            end
            else if (wb_adr == ble_pkg::BLE_REG_FLAGS)
            begin
                next_dat_r = {29'h0000_0000, flags};
            end
            else if (wb_adr == ble_pkg::BLE_REG_STAT)
            begin
                next_dat_r = {28'h000_0000, unsup, skip_pend, state};
            end
            else if (wb_adr == ble_pkg::BLE_REG_PORT)
            begin
                next_dat_r = {16'h0000, dir, latch};
            end
            else if (wb_adr == ble_pkg::BLE_REG_PRESC)
            begin
                next_dat_r = {24'h00_0000, presc};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_run <= 1'b0;
            ctl_pre_tmr <= 1'b0;
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end
        else
        begin
            ctl_run <= next_ctl_run;
            ctl_pre_tmr <= next_ctl_pre_tmr;
            wb_ack <= next_ack;
            wb_dat_r <= next_dat_r;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    add_to_acc_a: assert property (exec && is_add && !dbit |=>
        acc == $past(sum9[7:0]) && flags.carry == $past(sum9[8]))
        else $error("add result or carry wrong");
    and_zero_a: assert property (exec && is_andf |=>
        flags.zero == ($past(acc & opnd) == 8'h00) && flags.carry == $past(flags.carry))
        else $error("and with file flags wrong");
    and_lit_a: assert property (exec && is_andl |=> acc == $past(acc & lit))
        else $error("and literal result wrong");
    bit_clear_a: assert property (exec && is_bclr && fa != ble_pkg::BLE_FILE_PORT |->
        mem_we && (res & mask) == 8'h00 ##1 $stable(flags))
        else $error("bit clear wrong");
    bit_set_a: assert property (exec && is_bset |-> (res & mask) == mask
        && (res & ~mask) == (opnd & ~mask))
        else $error("bit set wrong");
    skip_arm_a: assert property (exec && (is_skc || is_sks) |=>
        skip_pend == $past(is_skc ? !opnd[bsel] : opnd[bsel]) && $stable(flags))
        else $error("skip decision wrong");
    skip_nop_a: assert property (accept && skip_pend |=>
        exec && ir == ble_pkg::BLE_OP_NOP ##1 instr_discard && !skip_pend)
        else $error("skipped word not discarded");
    port_rmw_a: assert property (exec && is_bset && fa == ble_pkg::BLE_FILE_PORT |=>
        port_out == $past(port_pins | mask))
        else $error("port read-modify-write wrong");
    dir_load_a: assert property (exec && is_dir |=> dir == $past(acc) && port_oe == ~$past(acc))
        else $error("direction latch load wrong");
    presc_clr_a: assert property (exec && to_file && fa == ble_pkg::BLE_FILE_TIMER
        && ctl_pre_tmr |=> prescale_clear && presc == 8'h00)
        else $error("prescaler not cleared");

    skip_seen_c: cover property (exec && do_skip ##2 instr_discard);
    port_rmw_c: cover property (exec && is_bclr && fa == ble_pkg::BLE_FILE_PORT);
    timer_clr_c: cover property (prescale_clear);
    add_carry_c: cover property (exec && is_add && sum9[8]);

endmodule

// ==== design/ble_pkg.sv ====
// constants, carrier types and register map of the bit and logic execute block
package ble_pkg;

    // ----------------------------------------------------------------
    // instruction word fields and codes
    // ----------------------------------------------------------------
    localparam int unsigned BLE_IW = 12;
    localparam logic [5:0] BLE_OP_ADD = 6'h07; // add_acc_to_file
    localparam logic [5:0] BLE_OP_ANDF = 6'h05; // and_acc_with_file
    localparam logic [5:0] BLE_OP_MOVE_FILE_VALUE = 6'h08; // move_file_value
    localparam logic [3:0] BLE_OP_ANDL = 4'he; // and_literal_to_acc
    localparam logic [3:0] BLE_OP_BCLR = 4'h4; // bit_clear_in_file
    localparam logic [3:0] BLE_OP_BSET = 4'h5; // bit_set_in_file
    localparam logic [3:0] BLE_OP_SKC = 4'h6; // skip_if_bit_clear
    localparam logic [3:0] BLE_OP_SKS = 4'h7; // skip_if_bit_set
    localparam logic [11:0] BLE_OP_DIR = 12'h006; // load_direction_latches of the port
    localparam logic [11:0] BLE_OP_NOP = 12'h000; // no_operation

    // ----------------------------------------------------------------
    // special file addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] BLE_FILE_TIMER = 5'h01; // timer_count_register
    localparam logic [4:0] BLE_FILE_PORT = 5'h06; // io_port_register

    // ----------------------------------------------------------------
    // bus register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] BLE_REG_CTRL = 8'h00;
    localparam logic [7:0] BLE_REG_ACC = 8'h04;
    localparam logic [7:0] BLE_REG_FLAGS = 8'h08;
    localparam logic [7:0] BLE_REG_STAT = 8'h0c;
    localparam logic [7:0] BLE_REG_PORT = 8'h10;
    localparam logic [7:0] BLE_REG_PRESC = 8'h14;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned BLE_CTRL_RUN = 0;
    localparam int unsigned BLE_CTRL_PRE_TMR = 1;
    localparam int unsigned BLE_STAT_SKIP = 2;
    localparam int unsigned BLE_STAT_UNSUP = 3;
    localparam logic [7:0] BLE_ACC_RST = 8'h00;
    localparam logic [7:0] BLE_LATCH_RST = 8'h00;
    localparam logic [7:0] BLE_DIR_RST = 8'hff;
    localparam logic [7:0] BLE_PRESC_RST = 8'h00;

    // status flags of the core
    typedef struct packed {
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } ble_flags_t;

    localparam ble_flags_t BLE_FLAGS_RST = 3'h0;

    // execute sequencer, one-hot
    typedef enum logic [1:0] {
        BLE_S_IDLE = 2'b01,
        BLE_S_EXEC = 2'b10
    } ble_state_t;

endpackage

// ==== design/ble_regfile.sv ====
// 32 x 8 file register memory with registered read data
`timescale 1ns/1ps
module ble_regfile
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data
);

    logic [7:0] mem [0:31];
    logic [7:0] next_rd_data;

    // read port, data valid one edge after the address
    always_comb
    begin
        next_rd_data = mem[rd_addr];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= next_rd_data;
        end
    end

    // write port, storage carries no reset
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule

// ==== bench/ble_fetch_model.sv ====
// behavioural fetch stage offering instruction words to the core
`timescale 1ns/1ps
module ble_fetch_model
(
    input wire logic clk_sys,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [11:0] instr_word
);
    // ----------------------------------------------------------------
    // idle state: word line shows zero before the first word, then the inverse of the last word
    // ----------------------------------------------------------------
    initial
    begin
        instr_valid = 1'b0;
        instr_word = 12'h000;
    end

    // offer one word and hold it until the core takes it
    task automatic issue(input logic [11:0] w);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= w;
        do @(posedge clk_sys); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        instr_word <= ~w;
    endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking testbench for the bit and logic execute core
`timescale 1ns/1ps
module testbench;
    logic clk_sys, rst_n, instr_valid, instr_ready, instr_discard, skip_taken, prescale_clear;
    logic [11:0] instr_word;
    logic [7:0] port_pins, port_out, port_oe, wb_adr;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    int fail_count = 0;
    int checks = 0;
    int n_skip = 0;
    int n_disc = 0;
    int n_clr = 0;

    ble_core ble_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .instr_discard(instr_discard),
        .skip_taken(skip_taken), .port_pins(port_pins), .port_out(port_out),
        .port_oe(port_oe), .prescale_clear(prescale_clear), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
    ble_fetch_model ble_fetch_model_inst (.clk_sys(clk_sys), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr_word(instr_word));

    // ----------------------------------------------------------------
    // clock and pulse counters
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // count one-cycle pulses of the core
    always @(posedge clk_sys)
    begin
        n_skip += (skip_taken === 1'b1);
        n_disc += (instr_discard === 1'b1);
        n_clr += (prescale_clear === 1'b1);
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do @(posedge clk_sys); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic exec(input logic [11:0] w);
        ble_fetch_model_inst.issue(w);
        repeat (3) @(posedge clk_sys);
    endtask

    // file cell := v by clearing it with and then adding v
    task automatic load(input logic [4:0] f, input logic [7:0] v);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        exec({ble_pkg::BLE_OP_ANDF, 1'b1, f});
        wb(1'b1, ble_pkg::BLE_REG_ACC, {24'h00_0000, v});
        exec({ble_pkg::BLE_OP_ADD, 1'b1, f});
    endtask

    // copy file cell into the accumulator through and with ff
    task automatic peek(input logic [4:0] f);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_00ff);
        exec({ble_pkg::BLE_OP_ANDF, 1'b0, f});
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        wb(1'b0, ble_pkg::BLE_REG_PORT, 32'h0000_0000);
        chk(q, 32'h0000_ff00);
        chk({24'h00_0000, port_oe}, 32'h0000_0000);
        wb(1'b0, 8'h20, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b1, ble_pkg::BLE_REG_CTRL, 32'h0000_0001);
    endtask

    task automatic t_add_and();
        load(5'h03, 8'h88);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_0078);
        exec({ble_pkg::BLE_OP_ADD, 1'b0, 5'h03});
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, ble_pkg::BLE_REG_FLAGS, 32'h0000_0000);
        chk(q, 32'h0000_0007);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_0001);
        exec({ble_pkg::BLE_OP_ADD, 1'b1, 5'h03});
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        wb(1'b0, ble_pkg::BLE_REG_FLAGS, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        peek(5'h03);
        chk(q, 32'h0000_0089);
        wb(1'b1, ble_pkg::BLE_REG_FLAGS, 32'h0000_0003);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_005a);
        exec({ble_pkg::BLE_OP_ANDL, 8'ha5});
        wb(1'b0, ble_pkg::BLE_REG_FLAGS, 32'h0000_0000);
        chk(q, 32'h0000_0007);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_00f0);
        exec({ble_pkg::BLE_OP_ANDL, 8'h3c});
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        chk(q, 32'h0000_0030);
        wb(1'b0, ble_pkg::BLE_REG_FLAGS, 32'h0000_0000);
        chk(q, 32'h0000_0003);
    endtask

    task automatic t_bits();
        load(5'h1f, 8'h7e);
        wb(1'b1, ble_pkg::BLE_REG_FLAGS, 32'h0000_0005);
        exec({ble_pkg::BLE_OP_BSET, 3'h7, 5'h1f});
        exec({ble_pkg::BLE_OP_BCLR, 3'h1, 5'h1f});
        wb(1'b0, ble_pkg::BLE_REG_FLAGS, 32'h0000_0000);
        chk(q, 32'h0000_0005);
        peek(5'h1f);
        chk(q, 32'h0000_00fc);
    endtask

    task automatic t_skip();
        int s0;
        int d0;
        load(5'h05, 8'h04);
        wb(1'b1, ble_pkg::BLE_REG_FLAGS, 32'h0000_0006);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_0033);
        s0 = n_skip;
        d0 = n_disc;
        exec({ble_pkg::BLE_OP_SKC, 3'h2, 5'h05});
        exec({ble_pkg::BLE_OP_SKS, 3'h3, 5'h05});
        chk(n_skip - s0, 32'h0000_0000);
        exec({ble_pkg::BLE_OP_SKS, 3'h2, 5'h05});
        exec({ble_pkg::BLE_OP_ANDL, 8'h00});
        exec({ble_pkg::BLE_OP_SKC, 3'h3, 5'h05});
        exec({ble_pkg::BLE_OP_ANDL, 8'h00});
        chk(n_skip - s0, 32'h0000_0002);
        chk(n_disc - d0, 32'h0000_0002);
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        chk(q, 32'h0000_0033);
        wb(1'b0, ble_pkg::BLE_REG_FLAGS, 32'h0000_0000);
        chk(q, 32'h0000_0006);
    endtask

    // move from file and an undecoded word flagged in the sticky status bit
    task automatic t_move();
        exec({ble_pkg::BLE_OP_MOVE_FILE_VALUE, 1'b0, 5'h05});
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        chk(q, 32'h0000_0004);
        exec(12'hfff);
        wb(1'b0, ble_pkg::BLE_REG_STAT, 32'h0000_0000);
        chk(q, 32'h0000_0009);
        wb(1'b1, ble_pkg::BLE_REG_STAT, 32'h0000_0008);
        wb(1'b0, ble_pkg::BLE_REG_STAT, 32'h0000_0000);
        chk(q, 32'h0000_0001);
    endtask

    task automatic t_port_timer();
        int c0;
        // timer cell starts unknown, so give it a value while no clear is armed
        load(ble_pkg::BLE_FILE_TIMER, 8'h10);
        wb(1'b1, ble_pkg::BLE_REG_ACC, 32'h0000_00f0);
        exec(ble_pkg::BLE_OP_DIR);
        chk({24'h00_0000, port_oe}, 32'h0000_000f);
        exec({ble_pkg::BLE_OP_BSET, 3'h7, ble_pkg::BLE_FILE_PORT});
        chk({24'h00_0000, port_out}, 32'h0000_0080);
        port_pins <= 8'h01;
        exec({ble_pkg::BLE_OP_BSET, 3'h1, ble_pkg::BLE_FILE_PORT});
        chk({24'h00_0000, port_out}, 32'h0000_0003);
        wb(1'b1, ble_pkg::BLE_REG_CTRL, 32'h0000_0003);
        c0 = n_clr;
        exec({ble_pkg::BLE_OP_BSET, 3'h0, ble_pkg::BLE_FILE_TIMER});
        chk(n_clr - c0, 32'h0000_0001);
        exec({ble_pkg::BLE_OP_ADD, 1'b0, ble_pkg::BLE_FILE_TIMER});
        wb(1'b0, ble_pkg::BLE_REG_ACC, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        wb(1'b1, ble_pkg::BLE_REG_CTRL, 32'h0000_0001);
        exec({ble_pkg::BLE_OP_BCLR, 3'h0, ble_pkg::BLE_FILE_TIMER});
        chk(n_clr - c0, 32'h0000_0001);
    endtask

    // ----------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        wrap_up();
    end

    initial
    begin
        rst_n = 1'b0;
        port_pins = 8'h00;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'hf;
        wb_dat_w = 32'h0000_0000;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_add_and();
        t_bits();
        t_skip();
        t_move();
        t_port_timer();
        wrap_up();
    end
endmodule
